// *** rtl/pwm_unit_pkg.sv ***
// Constants for the eight-bit PWM waveform unit.
package pwm_unit_pkg;
    localparam logic [2:0] WGM_PC_FF = 3'h1;
    localparam logic [2:0] WGM_FAST_FF = 3'h3;
    localparam logic [2:0] WGM_PC_OCA = 3'h5;
    localparam logic [2:0] WGM_FAST_OCA = 3'h7;
    localparam int WGM_BIT2 = 2;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;
    localparam int COM_HI = 1;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hff;
    localparam logic [2:0] PRE_STOP = 3'h0;
    localparam logic [2:0] PRE_1 = 3'h1;
    localparam logic [2:0] PRE_8 = 3'h2;
    localparam logic [2:0] PRE_64 = 3'h3;
    localparam logic [2:0] PRE_256 = 3'h4;
    localparam logic [2:0] PRE_1024 = 3'h5;
    localparam logic [9:0] DIV_8_LAST = 10'h007;
    localparam logic [9:0] DIV_64_LAST = 10'h03f;
    localparam logic [9:0] DIV_256_LAST = 10'h0ff;
    localparam logic [9:0] DIV_1024_LAST = 10'h3ff;
    localparam logic RESET_OUT = 1'b0;
endpackage

// *** rtl/tick_divider.sv ***
// Prescaler that makes the timer tick enable from the I/O clock.
`timescale 1ns/1ps
module tick_divider (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [2:0] prescale_select_i,
    output logic timer_tick_enable_o
);
    logic [9:0] count_q;
    logic [9:0] last;

    always_comb begin
        case (prescale_select_i)
            pwm_unit_pkg::PRE_8: last = pwm_unit_pkg::DIV_8_LAST;
            pwm_unit_pkg::PRE_64: last = pwm_unit_pkg::DIV_64_LAST;
            pwm_unit_pkg::PRE_256: last = pwm_unit_pkg::DIV_256_LAST;
            pwm_unit_pkg::PRE_1024: last = pwm_unit_pkg::DIV_1024_LAST;
            default: last = 10'h000;
        endcase
    end

    // The tick is a one-cycle enable, never a derived clock.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            count_q <= 10'h000;
            timer_tick_enable_o <= 1'b0;
        end else if (prescale_select_i == pwm_unit_pkg::PRE_STOP ||
                     prescale_select_i > pwm_unit_pkg::PRE_1024) begin
            count_q <= 10'h000;
            timer_tick_enable_o <= 1'b0;
        end else if (count_q >= last) begin
            count_q <= 10'h000;
            timer_tick_enable_o <= 1'b1;
        end else begin
            count_q <= count_q + 10'h001;
            timer_tick_enable_o <= 1'b0;
        end
    end
endmodule // tick_divider

// *** rtl/pwm_waveform_unit.sv ***
// Eight-bit timer in fast and phase correct PWM with two compare outputs.
`timescale 1ns/1ps
module pwm_waveform_unit #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [2:0] waveform_mode_field_i,
    input wire logic [2:0] prescale_select_i,
    input wire logic [1:0] compare_output_mode_a_i,
    input wire logic [1:0] compare_output_mode_b_i,
    input wire logic [WIDTH-1:0] compare_value_a_i,
    input wire logic [WIDTH-1:0] compare_value_b_i,
    input wire logic direction_a_i,
    input wire logic direction_b_i,
    input wire logic port_value_a_i,
    input wire logic port_value_b_i,
    input wire logic overflow_flag_clear_i,
    input wire logic compare_flag_a_clear_i,
    input wire logic compare_flag_b_clear_i,
    output logic [WIDTH-1:0] counter_value_o,
    output logic count_down_o,
    output logic compare_output_a_o,
    output logic compare_output_b_o,
    output logic pin_a_o,
    output logic pin_a_oe_o,
    output logic pin_b_o,
    output logic pin_b_oe_o,
    output logic overflow_flag_o,
    output logic compare_flag_a_o,
    output logic compare_flag_b_o
);
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_FAST = 3'b010,
        MODE_PHASE = 3'b100
    } mode_e;

    localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam logic [WIDTH-1:0] ZERO = '0;
    localparam logic [WIDTH-1:0] FULL = '1;

    logic tick;
    mode_e mode;
    logic [WIDTH-1:0] top;
    logic [WIDTH-1:0] ocr_a_q;
    logic [WIDTH-1:0] ocr_b_q;
    logic match_a;
    logic match_b;
    logic at_top;
    logic pending_a_q;
    logic pending_b_q;
    logic wrap;
    logic out_a_d;
    logic out_b_d;

    tick_divider u_tick_divider (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .prescale_select_i(prescale_select_i),
        .timer_tick_enable_o(tick)
    );

    // Decodes the waveform mode into an operating style.
    always_comb begin
        case (waveform_mode_field_i)
            pwm_unit_pkg::WGM_FAST_FF: mode = MODE_FAST;
            pwm_unit_pkg::WGM_FAST_OCA: mode = MODE_FAST;
            pwm_unit_pkg::WGM_PC_FF: mode = MODE_PHASE;
            pwm_unit_pkg::WGM_PC_OCA: mode = MODE_PHASE;
            default: mode = MODE_IDLE;
        endcase
    end

    // Mode bit 2 selects compare A as TOP in both PWM styles.
    assign top = waveform_mode_field_i[pwm_unit_pkg::WGM_BIT2] ?
                 ocr_a_q : FULL;
    assign at_top = (counter_value_o == top);
    assign match_a = (counter_value_o == ocr_a_q);
    assign match_b = (counter_value_o == ocr_b_q);
    assign wrap = (mode == MODE_FAST) && at_top;

    // Returns the next output level for one channel.
    function automatic logic next_out(
        input logic cur,
        input mode_e md,
        input logic [1:0] com,
        input logic toggle_ok,
        input logic match,
        input logic match_is_top,
        input logic at_top_now,
        input logic down,
        input logic at_bottom,
        input logic pending
    );
        logic r;
        r = cur;
        if (md == MODE_FAST) begin
            if (com == pwm_unit_pkg::COM_TOGGLE) begin
                if (toggle_ok && match) begin
                    r = ~cur;
                end
            end else if (com[pwm_unit_pkg::COM_HI]) begin
                if (at_top_now) begin
                    r = (com == pwm_unit_pkg::COM_INV) ? 1'b0 : 1'b1;
                end else if (match && !match_is_top) begin
                    r = (com == pwm_unit_pkg::COM_INV);
                end
            end
        end else if (md == MODE_PHASE) begin
            if (com == pwm_unit_pkg::COM_TOGGLE) begin
                if (toggle_ok && match) begin
                    r = ~cur;
                end
            end else if (com[pwm_unit_pkg::COM_HI]) begin
                if (match && match_is_top) begin
                    // At TOP the down-counting level holds, so MAX stays put.
                    r = (com != pwm_unit_pkg::COM_INV);
                end else if (match && !down) begin
                    r = (com == pwm_unit_pkg::COM_INV);
                end else if (match && down) begin
                    r = (com != pwm_unit_pkg::COM_INV);
                end else if (at_bottom && pending) begin
                    r = (com == pwm_unit_pkg::COM_INV);
                end
            end
        end
        return r;
    endfunction

    // Active compare values are refreshed only at TOP in PWM styles.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ocr_a_q <= ZERO;
            ocr_b_q <= ZERO;
        end else if (mode == MODE_IDLE) begin
            ocr_a_q <= compare_value_a_i;
            ocr_b_q <= compare_value_b_i;
        end else if (tick && at_top) begin
            ocr_a_q <= compare_value_a_i;
            ocr_b_q <= compare_value_b_i;
        end
    end

    // Counter: single slope wraps after TOP, dual slope reverses at TOP.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            counter_value_o <= ZERO;
            count_down_o <= 1'b0;
        end else if (tick) begin
            case (mode)
                MODE_FAST: begin
                    count_down_o <= 1'b0;
                    counter_value_o <= at_top ? ZERO :
                                       counter_value_o + ONE;
                end
                MODE_PHASE: begin
                    if (!count_down_o && at_top) begin
                        count_down_o <= 1'b1;
                        counter_value_o <= counter_value_o - ONE;
                    end else if (count_down_o &&
                                 counter_value_o == ONE) begin
                        count_down_o <= 1'b0;
                        counter_value_o <= ZERO;
                    end else if (count_down_o) begin
                        counter_value_o <= counter_value_o - ONE;
                    end else begin
                        counter_value_o <= counter_value_o + ONE;
                    end
                end
                default: begin
                    counter_value_o <= counter_value_o + ONE;
                    count_down_o <= 1'b0;
                end
            endcase
        end
    end

    // A pending flag means the up-counting match of this slope was missed.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pending_a_q <= 1'b0;
            pending_b_q <= 1'b0;
        end else if (tick && mode == MODE_PHASE) begin
            if (counter_value_o == ZERO) begin
                pending_a_q <= 1'b0;
                pending_b_q <= 1'b0;
            end else if (!count_down_o && at_top) begin
                // Output not yet at its up-match level means a missed match.
                // A value that stays at TOP keeps its level, so none is due.
                pending_a_q <= (compare_output_a_o !=
                    (compare_output_mode_a_i == pwm_unit_pkg::COM_INV)) &&
                    (compare_value_a_i != top);
                pending_b_q <= (compare_output_b_o !=
                    (compare_output_mode_b_i == pwm_unit_pkg::COM_INV)) &&
                    (compare_value_b_i != top);
            end
        end
    end

    assign out_a_d = next_out(compare_output_a_o, mode,
        compare_output_mode_a_i,
        waveform_mode_field_i[pwm_unit_pkg::WGM_BIT2], match_a,
        (ocr_a_q == top), wrap, count_down_o,
        count_down_o && counter_value_o == ONE, pending_a_q);
    assign out_b_d = next_out(compare_output_b_o, mode,
        compare_output_mode_b_i, 1'b0, match_b,
        (ocr_b_q == top), wrap, count_down_o,
        count_down_o && counter_value_o == ONE, pending_b_q);

    // Internal compare output registers.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            compare_output_a_o <= pwm_unit_pkg::RESET_OUT;
            compare_output_b_o <= pwm_unit_pkg::RESET_OUT;
        end else if (tick) begin
            compare_output_a_o <= out_a_d;
            compare_output_b_o <= out_b_d;
        end
    end

    // Pin override: waveform replaces the port value when the field connects.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pin_a_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_a_oe_o <= 1'b0;
            pin_b_oe_o <= 1'b0;
        end else begin
            pin_a_o <= drives_pin(compare_output_mode_a_i,
                           waveform_mode_field_i[pwm_unit_pkg::WGM_BIT2]) ?
                       out_a_d_view(1'b1) : port_value_a_i;
            pin_b_o <= drives_pin(compare_output_mode_b_i, 1'b0) ?
                       out_a_d_view(1'b0) : port_value_b_i;
            pin_a_oe_o <= direction_a_i;
            pin_b_oe_o <= direction_b_i;
        end
    end

    // Picks the level the internal register takes this cycle.
    function automatic logic out_a_d_view(input logic chan_a);
        logic r;
        r = chan_a ? (tick ? out_a_d : compare_output_a_o) :
                     (tick ? out_b_d : compare_output_b_o);
        return r;
    endfunction

    // The toggle setting connects a pin only where toggling is offered.
    function automatic logic drives_pin(input logic [1:0] com,
                                        input logic toggle_ok);
        logic r;
        r = com[pwm_unit_pkg::COM_HI] ||
            (com == pwm_unit_pkg::COM_TOGGLE && toggle_ok);
        return r;
    endfunction

    // Flags: set wins over a same-cycle clear.
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            overflow_flag_o <= 1'b0;
            compare_flag_a_o <= 1'b0;
            compare_flag_b_o <= 1'b0;
        end else begin
            if (tick && ((mode == MODE_PHASE && count_down_o &&
                          counter_value_o == ONE) ||
                         (mode != MODE_PHASE && wrap))) begin
                overflow_flag_o <= 1'b1;
            end else if (overflow_flag_clear_i) begin
                overflow_flag_o <= 1'b0;
            end
            if (tick && match_a) begin
                compare_flag_a_o <= 1'b1;
            end else if (compare_flag_a_clear_i) begin
                compare_flag_a_o <= 1'b0;
            end
            if (tick && match_b) begin
                compare_flag_b_o <= 1'b1;
            end else if (compare_flag_b_clear_i) begin
                compare_flag_b_o <= 1'b0;
            end
        end
    end
endmodule // pwm_waveform_unit

// *** tb/pwm_waveform_unit_chk.sv ***
// Port-level assertions for the PWM waveform unit.
`timescale 1ns/1ps
module pwm_waveform_unit_chk #(
    parameter int WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [2:0] waveform_mode_field_i,
    input wire logic [2:0] prescale_select_i,
    input wire logic [1:0] compare_output_mode_a_i,
    input wire logic [1:0] compare_output_mode_b_i,
    input wire logic [WIDTH-1:0] compare_value_a_i,
    input wire logic direction_a_i,
    input wire logic [WIDTH-1:0] counter_value_o,
    input wire logic count_down_o,
    input wire logic compare_output_a_o,
    input wire logic compare_output_b_o,
    input wire logic pin_a_o,
    input wire logic pin_a_oe_o,
    input wire logic overflow_flag_o,
    input wire logic compare_flag_a_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic fast_q;
    logic pc_q;
    wire logic pre1 = prescale_select_i == pwm_unit_pkg::PRE_1;
    wire logic fast_now = waveform_mode_field_i == pwm_unit_pkg::WGM_FAST_FF;
    wire logic pc_now = waveform_mode_field_i == pwm_unit_pkg::WGM_PC_FF;
    // A mode must have been steady for a cycle so a stale tick is not judged.
    wire logic fs = fast_now && pre1 && fast_q;
    wire logic ps = pc_now && pre1 && pc_q;
    always_ff @(posedge clock_i) begin
        fast_q <= fast_now && pre1 && rstn_i;
        pc_q <= pc_now && pre1 && rstn_i;
    end
    sequence s_top_near;
        ps && counter_value_o == 8'hfe && !count_down_o ##1 ps;
    endsequence
    sequence s_top_hold;
        counter_value_o == 8'hff ##1 counter_value_o == 8'hfe && count_down_o;
    endsequence
    a_top_held_once: assert property (s_top_near |-> s_top_hold)
        else $error("counter did not hold top for one tick");
    a_pc_bottom_flag: assert property (
        ps && counter_value_o == 8'h01 && count_down_o
        |=> counter_value_o == 8'h00 && overflow_flag_o)
        else $error("overflow flag not set at bottom");
    a_fast_wrap: assert property (
        fs && counter_value_o == 8'hff
        |=> counter_value_o == 8'h00 && overflow_flag_o)
        else $error("fast counter did not wrap with overflow");
    a_top_level: assert property (
        fs && counter_value_o == 8'hff && compare_output_mode_a_i[1]
        |=> compare_output_a_o == !$past(compare_output_mode_a_i[0]))
        else $error("wrong output level after wrap");
    a_match_level: assert property (
        fs && compare_output_mode_a_i[1] && compare_value_a_i != 8'hff
        && counter_value_o == compare_value_a_i
        |=> compare_output_a_o == $past(compare_output_mode_a_i[0]))
        else $error("wrong output level after compare match");
    a_match_flag: assert property (
        fs && counter_value_o == compare_value_a_i |=> compare_flag_a_o)
        else $error("compare flag not set after match");
    a_b_no_toggle: assert property (
        $past(rstn_i) && $past(compare_output_mode_b_i) == 2'h1
        |-> $stable(compare_output_b_o))
        else $error("output b changed in toggle setting");
    a_pin_shows_oc: assert property (
        $past(rstn_i) && $past(compare_output_mode_a_i[1])
        |-> pin_a_o == compare_output_a_o)
        else $error("pin does not show compare output");
    a_oe_follows_dir: assert property (
        $past(rstn_i) && $past(rstn_i, 2) |-> pin_a_oe_o == $past(direction_a_i))
        else $error("pin enable does not follow direction");
    a_reset_clears: assert property (disable iff (1'b0)
        !rstn_i |=> !compare_output_a_o && !compare_output_b_o)
        else $error("reset did not clear compare outputs");
endmodule // pwm_waveform_unit_chk

// *** tb/tb.sv ***
// Directed test bench for the PWM waveform unit.
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] wgm = 3'h0;
    logic [2:0] pre = 3'h1;
    logic [1:0] com_a = 2'h0;
    logic [1:0] com_b = 2'h0;
    logic [7:0] cmp_a = 8'h00;
    logic [7:0] cmp_b = 8'h00;
    logic dir_a = 1'b1;
    logic dir_b = 1'b1;
    logic port_a = 1'b1;
    logic port_b = 1'b0;
    logic clr = 1'b0;
    logic [7:0] cnt;
    logic down, oc_a, oc_b, pin_a, oe_a, pin_b, oe_b, ovf, fa, fb;
    int fail_count = 0;
    int total_checks = 0;
    pwm_waveform_unit #(.WIDTH(8)) uut (.clock_i(clock_i), .rstn_i(rstn_i),
        .waveform_mode_field_i(wgm), .prescale_select_i(pre),
        .compare_output_mode_a_i(com_a), .compare_output_mode_b_i(com_b),
        .compare_value_a_i(cmp_a), .compare_value_b_i(cmp_b),
        .direction_a_i(dir_a), .direction_b_i(dir_b),
        .port_value_a_i(port_a), .port_value_b_i(port_b),
        .overflow_flag_clear_i(clr), .compare_flag_a_clear_i(clr),
        .compare_flag_b_clear_i(clr), .counter_value_o(cnt),
        .count_down_o(down), .compare_output_a_o(oc_a),
        .compare_output_b_o(oc_b), .pin_a_o(pin_a), .pin_a_oe_o(oe_a),
        .pin_b_o(pin_b), .pin_b_oe_o(oe_b), .overflow_flag_o(ovf),
        .compare_flag_a_o(fa), .compare_flag_b_o(fb));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_num(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    // The flag is sticky, so the period runs from one set to the next.
    task automatic ovf_period(output int n);
        n = 0;
        while (ovf !== 1'b1 && n < 70000) begin
            @(posedge clock_i);
            n++;
        end
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        n = 1;
        do begin
            @(posedge clock_i);
            n++;
        end while (ovf !== 1'b1 && n < 70000);
    endtask
    // Waits for a counter value on one slope; a missing value is a mismatch.
    task automatic wait_count(input logic [7:0] v, input logic dn);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (!(cnt === v && down === dn) && n < 2000);
        if (n >= 2000) begin
            fail_count++;
            $display("CHECK FAILED counter expected %0d seen %0d", v, cnt);
        end
    endtask
    task automatic run_case(input logic [2:0] m, input logic [2:0] p,
        input logic [1:0] ca, input logic [1:0] cb, input logic [7:0] va,
        input logic [7:0] vb, input int per, input int len, input int ea,
        input int eb);
        int n;
        int a;
        int b;
        // Idle mode takes new compare values at once, so no stale value lingers.
        wgm <= 3'h0;
        pre <= p;
        cmp_a <= va;
        cmp_b <= vb;
        clr <= 1'b1;
        repeat (2) @(posedge clock_i);
        clr <= 1'b0;
        wgm <= m;
        com_a <= ca;
        com_b <= cb;
        ovf_period(n);
        chk_num("period", per, n);
        a = 0;
        b = 0;
        repeat (len) begin
            @(posedge clock_i);
            if (pin_a === 1'b1) a++;
            if (pin_b === 1'b1) b++;
        end
        chk_num("pin_a highs", ea, a);
        chk_num("pin_b highs", eb, b);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        chk_bit("compare_output_a_o", 1'b0, oc_a);
        chk_bit("compare_output_b_o", 1'b0, oc_b);
        run_case(3, 1, 2, 3, 8'h80, 8'h40, 256, 256, 129, 191);
        run_case(3, 2, 2, 3, 8'h80, 8'h40, 2048, 2048, 1032, 1528);
        run_case(3, 3, 2, 3, 8'h80, 8'h40, 16384, 16384, 8256, 12224);
        run_case(3, 1, 2, 3, 8'h00, 8'hff, 256, 256, 1, 0);
        run_case(3, 1, 2, 2, 8'hff, 8'hff, 256, 256, 256, 256);
        run_case(7, 1, 1, 1, 8'h3f, 8'h10, 64, 128, 64, 0);
        run_case(3, 1, 1, 0, 8'h80, 8'h80, 256, 256, 256, 0);
        run_case(1, 1, 2, 3, 8'h80, 8'h80, 510, 510, 256, 254);
        run_case(5, 1, 0, 2, 8'h40, 8'h20, 128, 128, 128, 64);
        run_case(1, 1, 2, 2, 8'h00, 8'hff, 510, 510, 0, 510);
        // Leaving MAX: the new value loads at TOP, then a drop at BOTTOM.
        cmp_b <= 8'h80;
        wait_count(8'hff, 1'b0);
        wait_count(8'h40, 1'b0);
        chk_bit("compare_output_b_o", 1'b0, oc_b);
        wait_count(8'h40, 1'b0);
        chk_bit("compare_output_b_o", 1'b1, oc_b);
        run_case(1, 1, 3, 3, 8'h00, 8'hff, 510, 510, 510, 0);
        run_case(1, 1, 1, 0, 8'h80, 8'h80, 510, 510, 510, 0);
        run_case(5, 1, 1, 0, 8'h40, 8'h20, 128, 256, 128, 0);
        chk_bit("compare_flag_b_o", 1'b1, fb);
        pre <= 3'h0;
        clr <= 1'b1;
        repeat (2) @(posedge clock_i);
        clr <= 1'b0;
        @(posedge clock_i);
        chk_bit("compare_flag_b_o", 1'b0, fb);
        chk_bit("compare_flag_a_o", 1'b0, fa);
        dir_a <= 1'b0;
        dir_b <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk_bit("pin_a_oe_o", 1'b0, oe_a);
        chk_bit("pin_b_oe_o", 1'b0, oe_b);
        dir_a <= 1'b1;
        dir_b <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk_bit("pin_a_oe_o", 1'b1, oe_a);
        chk_bit("pin_b_oe_o", 1'b1, oe_b);
        report_and_stop();
    end
    initial begin
        #450000;
        fail_count++;
        report_and_stop();
    end
endmodule // tb
bind pwm_waveform_unit pwm_waveform_unit_chk #(.WIDTH(WIDTH)) chk_i (
    .clock_i(clock_i), .rstn_i(rstn_i),
    .waveform_mode_field_i(waveform_mode_field_i),
    .prescale_select_i(prescale_select_i),
    .compare_output_mode_a_i(compare_output_mode_a_i),
    .compare_output_mode_b_i(compare_output_mode_b_i),
    .compare_value_a_i(compare_value_a_i), .direction_a_i(direction_a_i),
    .counter_value_o(counter_value_o), .count_down_o(count_down_o),
    .compare_output_a_o(compare_output_a_o),
    .compare_output_b_o(compare_output_b_o), .pin_a_o(pin_a_o),
    .pin_a_oe_o(pin_a_oe_o), .overflow_flag_o(overflow_flag_o),
    .compare_flag_a_o(compare_flag_a_o));
